// ---- test_watchdog_reset.sv ----
// self-checking bench for the watchdog and reset-source block
// assumes bus overflow exponents shrunk to 4/5/6; the bench makes the 1 kHz ticks itself
`timescale 1ns/1ps
module test_watchdog_reset;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, reset_pin_n = 1'b1;
    logic lpo_clk = 1'b0, low_voltage_detect = 1'b0, illegal_opcode_reset = 1'b0;
    logic illegal_address_reset = 1'b0, debug_forced_reset = 1'b0;
    logic debug_active = 1'b0, stop_mode = 1'b0, system_reset, set_interrupt_mask;
    logic [7:0] addr = 8'h00, reset_cause, cause_seen = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, reset_vector_addr, stack_pointer_init, d;
    int bad_count = 0, n_checks = 0, n_rst = 0, n, b;

    watchdog_reset #(.BUS_EXP_SHORT(4), .BUS_EXP_MID(5), .BUS_EXP_LONG(6)) u_dut (.clk, .rst,
        .ce, .addr, .wdata, .wr, .rd, .rdata, .reset_pin_n, .lpo_clk, .low_voltage_detect,
        .illegal_opcode_reset, .illegal_address_reset, .debug_forced_reset, .debug_active,
        .stop_mode, .system_reset, .reset_cause, .set_interrupt_mask, .reset_vector_addr,
        .stack_pointer_init);

    always #4 clk = ~clk;
    // sampled mid-cycle so the tasks can read the tally at the edge without a race
    always @(negedge clk) if (system_reset === 1'b1) begin
        n_rst++;
        cause_seen = reset_cause;
    end

    task chk(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            bad_count++;
            $display("BAD t=%0t got %h want %h", $time, got, want);
        end
    endtask
    // h keeps the strobe up when another write follows at once
    task wr_t(input logic [7:0] a, input logic [15:0] v, input logic h = 1'b0);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk);
        if (!h) wr <= 1'b0;
    endtask
    task rd_t(input logic [7:0] a);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task wt(input int mx);
        b = n_rst; n = 0;
        while (n_rst == b && n < mx) begin
            @(posedge clk);
            n++;
        end
    endtask
    task lp(input int k);
        repeat (k) begin
            lpo_clk <= 1'b1;
            repeat (4) @(posedge clk);
            lpo_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    // option one: tsel in 7:6, pin enable in bit 0; option two: clock 7, window 6
    task cfg(input logic [1:0] t, input logic c, input logic w, input logic h = 1'b0);
        wr_t(8'h01, {8'h00, t, 6'h01}, 1'b1);
        wr_t(8'h02, {8'h00, c, w, 6'h00}, h);
    endtask
    task t_defaults();
        rd_t(8'h00); chk(d, 16'h0080);
        rd_t(8'h01); chk(d & 16'h80C1, 16'h00C1);
        rd_t(8'h02); chk(d & 16'h80C0, 16'h0000);
        b = n_rst; lp(1020); chk(n_rst - b, 0);
        lp(6); chk(n_rst - b, 1);
        chk(cause_seen, 8'h20);
        $display("done defaults");
    endtask
    task t_bus();
        for (int k = 1; k <= 3; k++) begin
            cfg(2'(k), 1'b1, 1'b0, 1'b1);
            wr_t(8'h01, 16'h0001);
            wt(200); chk(n >= (8 << k) - 3 && n <= (8 << k) + 2, 1);
        end
        $display("done bus");
    endtask
    task t_service();
        cfg(2'h1, 1'b1, 1'b0);
        b = n_rst;
        repeat (4) begin
            repeat (8) @(posedge clk);
            wr_t(8'h00, 16'h0055, 1'b1); wr_t(8'h00, 16'h00AA);
        end
        chk(n_rst - b, 0);
        rd_t(8'h00); chk(d, 16'h0020);
        wt(40); chk(cause_seen, 8'h20);
        $display("done service");
    endtask
    task t_window();
        cfg(2'h3, 1'b1, 1'b1); repeat (10) @(posedge clk);
        wr_t(8'h00, 16'h0055); wt(4); chk(n <= 2, 1);
        cfg(2'h3, 1'b1, 1'b1); repeat (52) @(posedge clk);
        wr_t(8'h00, 16'h0055, 1'b1); wr_t(8'h00, 16'h00AA); wt(40); chk(n, 40);
        wt(64);
        cfg(2'h3, 1'b0, 1'b1, 1'b1); wr_t(8'h00, 16'h0055); wt(20); chk(n, 20);
        wr_t(8'h00, 16'h0012); wt(4); chk(n <= 2, 1);
        cfg(2'h0, 1'b1, 1'b0); wt(300); chk(n, 300);
        wr_t(8'h00, 16'h00FF); wt(4);
        $display("done window");
    endtask
    task t_halt();
        cfg(2'h1, 1'b1, 1'b0); repeat (8) @(posedge clk);
        debug_active <= 1'b1; wt(40); chk(n, 40);
        debug_active <= 1'b0; wt(20); chk(n >= 3 && n <= 12, 1);
        cfg(2'h1, 1'b0, 1'b0); b = n_rst; lp(20);
        stop_mode <= 1'b1; repeat (3) @(posedge clk); stop_mode <= 1'b0;
        lp(20); chk(n_rst - b, 0);
        lp(16); chk(n_rst - b, 1);
        $display("done halt");
    endtask
    task t_sources();
        logic [7:0] want [6] = '{8'h02, 8'h10, 8'h08, 8'h00, 8'h40, 8'h08};
        for (int i = 0; i < 6; i++) begin
            case (i)
                0: low_voltage_detect <= 1'b1;
                1: illegal_opcode_reset <= 1'b1;
                2: illegal_address_reset <= 1'b1;
                3: debug_forced_reset <= 1'b1;
                4: reset_pin_n <= 1'b0;
                default: addr <= 8'h05;
            endcase
            if (i == 5) rd <= 1'b1;
            @(posedge clk);
            {low_voltage_detect, illegal_opcode_reset, illegal_address_reset} <= 3'h0;
            debug_forced_reset <= 1'b0; rd <= 1'b0;
            wt(8); chk(n < 8, 1); chk(cause_seen, want[i]);
            reset_pin_n <= 1'b1;
            rd_t(8'h00); chk(d, {8'h00, want[i]});
        end
        wr_t(8'h01, 16'h00C0); reset_pin_n <= 1'b0; wt(10); chk(n, 10);
        reset_pin_n <= 1'b1;
        $display("done sources");
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_defaults(); t_bus(); t_service(); t_window(); t_halt(); t_sources();
        finish_test();
    end
    initial begin
        #400000;
        bad_count++;
        finish_test();
    end
endmodule

// ---- watchdog_pkg.sv ----
// constants, field layout and types for the watchdog and reset-source block
// assumes one 125 MHz clock and a plain strobe register port
package watchdog_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CNT_W = 19;
    localparam int CAUSE_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] RESET_STATUS_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] SYSTEM_OPTION_ONE_OFS = 8'h01;
    localparam logic [ADDR_W-1:0] SYSTEM_OPTION_TWO_OFS = 8'h02;

    // service sequence values
    localparam logic [DATA_W-1:0] SERVICE_FIRST = 16'h0055;
    localparam logic [DATA_W-1:0] SERVICE_SECOND = 16'h00AA;

    // system_option_one fields
    localparam int TSEL_HI = 7;
    localparam int TSEL_LO = 6;
    localparam int PIN_EN_POS = 0;
    // system_option_two fields
    localparam int CLKSEL_POS = 7;
    localparam int WIN_EN_POS = 6;
    localparam int LOCK_POS = 15;

    // reset values: 1 kHz clock, longest timeout, no window, pin reset enabled
    localparam logic [1:0] TSEL_RST = 2'h3;
    localparam logic CLKSEL_RST = 1'b0;
    localparam logic WIN_EN_RST = 1'b0;
    localparam logic PIN_EN_RST = 1'b1;

    // reset_status bit positions
    localparam int ST_POR = 7;
    localparam int ST_PIN = 6;
    localparam int ST_WDOG = 5;
    localparam int ST_ILLEGAL_OPCODE_RESET = 4;
    localparam int ST_ILLEGAL_ADDRESS_RESET = 3;
    localparam int ST_LVD = 1;
    localparam logic [CAUSE_W-1:0] STATUS_RST = 8'h80;

    // overflow exponents for the low-power clock (period 1 ms)
    localparam int LPO_EXP_SHORT = 5;
    localparam int LPO_EXP_MID = 8;
    localparam int LPO_EXP_LONG = 10;
    localparam int LOW_POWER_CLOCK_PERIOD_US = 1000;
    // default overflow exponents for the bus clock
    localparam int BUS_EXP_SHORT = 13;
    localparam int BUS_EXP_MID = 16;
    localparam int BUS_EXP_LONG = 18;

    // values handed to the core on every system reset
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
    localparam logic [15:0] STACK_INIT = 16'h00FF;

    typedef enum logic {
        SVC_IDLE,
        SVC_ARMED
    } svc_state_t;

endpackage

// ---- watchdog_reset.sv ----
// watchdog counter, its service sequence, write-once options and reset-source recording
// assumes the core, memory decoder and voltage monitor share clk; the reset pin and
// the 1 kHz low-power clock arrive asynchronously and are synchronised here
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps

module watchdog_reset #(
    parameter int BUS_EXP_SHORT = watchdog_pkg::BUS_EXP_SHORT,
    parameter int BUS_EXP_MID = watchdog_pkg::BUS_EXP_MID,
    parameter int BUS_EXP_LONG = watchdog_pkg::BUS_EXP_LONG
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [watchdog_pkg::ADDR_W-1:0] addr,
    input wire logic [watchdog_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [watchdog_pkg::DATA_W-1:0] rdata,
    input wire logic reset_pin_n,
    input wire logic lpo_clk,
    input wire logic low_voltage_detect,
    input wire logic illegal_opcode_reset,
    input wire logic illegal_address_reset,
    input wire logic debug_forced_reset,
    input wire logic debug_active,
    input wire logic stop_mode,
    output logic system_reset,
    output logic [watchdog_pkg::CAUSE_W-1:0] reset_cause,
    output logic set_interrupt_mask,
    output logic [15:0] reset_vector_addr,
    output logic [15:0] stack_pointer_init
);

    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic lpo_s1;
        logic lpo_s2;
        logic lpo_prev;
        logic [1:0] timeout_select;
        logic pin_reset_enable;
        logic watchdog_clock_select;
        logic window_mode_enable;
        logic lock_one;
        logic lock_two;
        watchdog_pkg::svc_state_t svc;
        logic [watchdog_pkg::CNT_W-1:0] count;
        logic [watchdog_pkg::CAUSE_W-1:0] reset_status;
        logic [watchdog_pkg::DATA_W-1:0] rdata;
        logic [watchdog_pkg::CAUSE_W-1:0] cause;
        logic sys_reset;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // overflow count for the selected source and timeout code; zero means disabled
    function automatic logic [watchdog_pkg::CNT_W-1:0] ovf_limit(
        input logic bus_sel,
        input logic [1:0] tsel
    );
        int e;
        e = 0;
        unique case ({bus_sel, tsel})
            3'b001: e = watchdog_pkg::LPO_EXP_SHORT;
            3'b010: e = watchdog_pkg::LPO_EXP_MID;
            3'b011: e = watchdog_pkg::LPO_EXP_LONG;
            3'b101: e = BUS_EXP_SHORT;
            3'b110: e = BUS_EXP_MID;
            3'b111: e = BUS_EXP_LONG;
            default: e = -1;
        endcase
        if (e < 0) begin
            return '0;
        end
        return watchdog_pkg::CNT_W'(1) << e;
    endfunction

    // restores the watchdog configuration that every reset brings back
    function automatic state_t init_config(input state_t s);
        state_t t;
        t = s;
        t.timeout_select = watchdog_pkg::TSEL_RST;
        t.watchdog_clock_select = watchdog_pkg::CLKSEL_RST;
        t.window_mode_enable = watchdog_pkg::WIN_EN_RST;
        t.pin_reset_enable = watchdog_pkg::PIN_EN_RST;
        t.lock_one = 1'b0;
        t.lock_two = 1'b0;
        t.svc = watchdog_pkg::SVC_IDLE;
        t.count = '0;
        return t;
    endfunction

    logic lpo_tick;
    logic pin_event;
    logic halted;
    logic enabled;
    logic bus_sel;
    logic tick;
    logic timeout;
    logic mapped;
    logic bad_addr;
    logic window_on;
    logic too_early;
    logic svc_reset;
    logic [watchdog_pkg::CNT_W-1:0] limit;
    logic [watchdog_pkg::CNT_W-1:0] window_open;
    logic [watchdog_pkg::CAUSE_W-1:0] causes;

    always_comb begin
        s_nxt = s_r;
        lpo_tick = 1'b0;
        pin_event = 1'b0;
        halted = 1'b0;
        enabled = 1'b0;
        bus_sel = 1'b0;
        tick = 1'b0;
        timeout = 1'b0;
        mapped = 1'b0;
        bad_addr = 1'b0;
        window_on = 1'b0;
        too_early = 1'b0;
        svc_reset = 1'b0;
        limit = '0;
        window_open = '0;
        causes = '0;
        if (ce) begin
            s_nxt.cause = '0;
            s_nxt.sys_reset = 1'b0;
            s_nxt.rdata = '0;
            s_nxt.pin_s1 = reset_pin_n;
            s_nxt.pin_s2 = s_r.pin_s1;
            s_nxt.pin_prev = s_r.pin_s2;
            s_nxt.lpo_s1 = lpo_clk;
            s_nxt.lpo_s2 = s_r.lpo_s1;
            s_nxt.lpo_prev = s_r.lpo_s2;
            lpo_tick = s_r.lpo_s2 & ~s_r.lpo_prev;
            // pin reset taken on its assertion edge only while enabled
            pin_event = s_r.pin_reset_enable & s_r.pin_prev & ~s_r.pin_s2;
            halted = debug_active | stop_mode;
            bus_sel = s_r.watchdog_clock_select;
            limit = ovf_limit(bus_sel, s_r.timeout_select);
            enabled = s_r.timeout_select != 2'h0;
            window_open = limit - (limit >> 2);
            // window only exists on the bus clock
            window_on = enabled & bus_sel & s_r.window_mode_enable;
            too_early = window_on & (s_r.count < window_open);

            if (!enabled) begin
                s_nxt.count = '0;
            end else if (bus_sel) begin
                tick = ~halted;
            end else if (halted) begin
                s_nxt.count = '0;
            end else begin
                tick = lpo_tick;
            end
            if (tick) begin
                s_nxt.count = s_r.count + watchdog_pkg::CNT_W'(1);
            end
            timeout = tick & (s_r.count == limit - watchdog_pkg::CNT_W'(1));

            mapped = addr == watchdog_pkg::RESET_STATUS_OFS
                || addr == watchdog_pkg::SYSTEM_OPTION_ONE_OFS
                || addr == watchdog_pkg::SYSTEM_OPTION_TWO_OFS;
            bad_addr = (wr | rd) & ~mapped;

            // service writes never touch reset_status itself
            if (wr && addr == watchdog_pkg::RESET_STATUS_OFS) begin
                if (wdata == watchdog_pkg::SERVICE_FIRST) begin
                    svc_reset = too_early;
                    s_nxt.svc = watchdog_pkg::SVC_ARMED;
                end else if (wdata == watchdog_pkg::SERVICE_SECOND) begin
                    svc_reset = too_early;
                    s_nxt.svc = watchdog_pkg::SVC_IDLE;
                    if (s_r.svc == watchdog_pkg::SVC_ARMED) begin
                        s_nxt.count = '0;
                    end
                end else begin
                    svc_reset = 1'b1;
                end
            end
            // options are write-once; the first write also restarts the count
            if (wr && addr == watchdog_pkg::SYSTEM_OPTION_ONE_OFS && !s_r.lock_one) begin
                s_nxt.timeout_select = wdata[watchdog_pkg::TSEL_HI:watchdog_pkg::TSEL_LO];
                s_nxt.pin_reset_enable = wdata[watchdog_pkg::PIN_EN_POS];
                s_nxt.lock_one = 1'b1;
                s_nxt.count = '0;
            end
            if (wr && addr == watchdog_pkg::SYSTEM_OPTION_TWO_OFS && !s_r.lock_two) begin
                s_nxt.watchdog_clock_select = wdata[watchdog_pkg::CLKSEL_POS];
                s_nxt.window_mode_enable = wdata[watchdog_pkg::WIN_EN_POS];
                s_nxt.lock_two = 1'b1;
                s_nxt.count = '0;
            end

            if (rd) begin
                unique case (addr)
                    watchdog_pkg::RESET_STATUS_OFS: begin
                        s_nxt.rdata = {8'h00, s_r.reset_status};
                    end
                    watchdog_pkg::SYSTEM_OPTION_ONE_OFS: begin
                        s_nxt.rdata[watchdog_pkg::TSEL_HI:watchdog_pkg::TSEL_LO] =
                            s_r.timeout_select;
                        s_nxt.rdata[watchdog_pkg::PIN_EN_POS] = s_r.pin_reset_enable;
                        s_nxt.rdata[watchdog_pkg::LOCK_POS] = s_r.lock_one;
                    end
                    watchdog_pkg::SYSTEM_OPTION_TWO_OFS: begin
                        s_nxt.rdata[watchdog_pkg::CLKSEL_POS] = s_r.watchdog_clock_select;
                        s_nxt.rdata[watchdog_pkg::WIN_EN_POS] = s_r.window_mode_enable;
                        s_nxt.rdata[watchdog_pkg::LOCK_POS] = s_r.lock_two;
                    end
                    default: s_nxt.rdata = '0;
                endcase
            end

            causes[watchdog_pkg::ST_PIN] = pin_event;
            causes[watchdog_pkg::ST_WDOG] = timeout | svc_reset;
            causes[watchdog_pkg::ST_ILLEGAL_OPCODE_RESET] = illegal_opcode_reset;
            causes[watchdog_pkg::ST_ILLEGAL_ADDRESS_RESET] = illegal_address_reset | bad_addr;
            causes[watchdog_pkg::ST_LVD] = low_voltage_detect;

            // a reset overrides any register write landing in the same cycle
            if ((|causes) || debug_forced_reset) begin
                s_nxt = init_config(s_nxt);
                s_nxt.reset_status = causes;
                s_nxt.cause = causes;
                s_nxt.sys_reset = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.pin_s1 <= 1'b1;
            s_r.pin_s2 <= 1'b1;
            s_r.pin_prev <= 1'b1;
            s_r.timeout_select <= watchdog_pkg::TSEL_RST;
            s_r.watchdog_clock_select <= watchdog_pkg::CLKSEL_RST;
            s_r.window_mode_enable <= watchdog_pkg::WIN_EN_RST;
            s_r.pin_reset_enable <= watchdog_pkg::PIN_EN_RST;
            s_r.svc <= watchdog_pkg::SVC_IDLE;
            s_r.reset_status <= watchdog_pkg::STATUS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign system_reset = s_r.sys_reset;
    assign reset_cause = s_r.cause;
    assign set_interrupt_mask = s_r.sys_reset;
    assign reset_vector_addr = watchdog_pkg::RESET_VECTOR_ADDR;
    assign stack_pointer_init = watchdog_pkg::STACK_INIT;

endmodule

// ---- watchdog_reset_monitor.sv ----
// assertions on the ports of the watchdog and reset-source block
// assumes one clock clk and async high reset rst; bound to every watchdog_reset
`timescale 1ns/1ps
module watchdog_reset_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic low_voltage_detect,
    input wire logic illegal_opcode_reset,
    input wire logic debug_forced_reset,
    input wire logic system_reset,
    input wire logic [7:0] reset_cause,
    input wire logic set_interrupt_mask,
    input wire logic [15:0] reset_vector_addr,
    input wire logic [15:0] stack_pointer_init
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_MASK: assert property (set_interrupt_mask == system_reset)
        else $error("interrupt mask differs from reset pulse");
    AST_VEC: assert property (reset_vector_addr == 16'hFFFE &&
        stack_pointer_init == 16'h00FF)
        else $error("reset vector or stack value wrong");
    AST_PULSE: assert property (system_reset |=> !system_reset)
        else $error("reset pulse longer than one cycle");
    AST_CAUSE: assert property (reset_cause != 8'h00 |-> system_reset)
        else $error("cause without reset pulse");
    AST_BADVAL: assert property (ce && wr && addr == 8'h00 &&
        wdata != 16'h0055 && wdata != 16'h00AA |=> system_reset && reset_cause[5])
        else $error("bad service value did not reset");
    AST_LVD: assert property (ce && low_voltage_detect |=>
        system_reset && reset_cause[1])
        else $error("low voltage cause missing");
    AST_ILLEGAL_OPCODE_RESET: assert property (ce && illegal_opcode_reset |=> reset_cause[4])
        else $error("illegal opcode cause missing");
    AST_ILLEGAL_ADDRESS_RESET: assert property (ce && (wr || rd) && addr > 8'h02 |=> reset_cause[3])
        else $error("unmapped access did not reset");
    AST_DBG: assert property (ce && $rose(debug_forced_reset) |=> system_reset)
        else $error("debug forced reset missing");
    cover property (system_reset && reset_cause[5]);
    cover property (system_reset && reset_cause[3]);
    cover property (system_reset && reset_cause == 8'h00);
endmodule

bind watchdog_reset watchdog_reset_monitor u_monitor (.clk, .rst, .ce, .addr, .wdata, .wr, .rd,
    .low_voltage_detect, .illegal_opcode_reset, .debug_forced_reset, .system_reset,
    .reset_cause, .set_interrupt_mask, .reset_vector_addr, .stack_pointer_init);
